// ==== verilog/timer_counter.sv ====
// Purpose : 8-bit up-counter with timer, event, divider-output and PWM modes
// Assumes : sys_clk is the fast oscillator; divider taps and pins are synchronous
// Notes   : registers reached over AXI4-Lite, one aligned word each
`timescale 1ns/100ps
`include "tc_defines.svh"

module timer_counter
  import tc_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  // AXI4-Lite slave
  input  wire logic [`TC_ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [`TC_ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // clock sources and power state
  input  wire logic [`TC_FAST_TAPS-1:0]  fast_taps,
  input  wire logic                      slow_tap,
  input  wire logic                      prescaler_slow_select,
  input  wire logic                      prescaler_half_select,
  input  wire logic                      slow_power_mode,
  input  wire logic                      stop_entry,
  // pins and interrupt
  input  wire logic                      event_in,
  output logic                           divider_out,
  output logic                           pwm_out_n,
  output logic                           match_irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic                      awready_q, awready_d;
  logic                      wready_q, wready_d;
  logic                      aw_held_q, aw_held_d;
  logic                      w_held_q, w_held_d;
  logic [`TC_ADDR_W-1:0]     waddr_q, waddr_d;
  logic [7:0]                wbyte_q, wbyte_d;
  logic                      wlane_q, wlane_d;
  logic                      bvalid_q, bvalid_d;
  logic [1:0]                bresp_q, bresp_d;
  logic                      arready_q, arready_d;
  logic                      rvalid_q, rvalid_d;
  logic [31:0]               rdata_q, rdata_d;
  logic [1:0]                rresp_q, rresp_d;

  byte_t                     ctrl_q, ctrl_d;
  byte_t                     cmp_q, cmp_d;
  byte_t                     shadow_q, shadow_d;
  byte_t                     cnt_q, cnt_d;
  logic                      pdo_q, pdo_d;
  logic                      pwm_n_q, pwm_n_d;
  logic                      irq_q, irq_d;
  logic [`TC_FAST_TAPS-1:0]  taps_q;
  logic                      slow_q;
  logic                      evt_q;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic                      ctrl_wr, cmp_wr;

  always_comb begin
    awready_d = awready_q;
    wready_d  = wready_q;
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    waddr_d   = waddr_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    ctrl_wr   = 1'b0;
    cmp_wr    = 1'b0;
    // address and data are taken in either order
    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      awready_d = 1'b0;
      waddr_d   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_held_d = 1'b1;
      wready_d = 1'b0;
      wbyte_d  = s_axi_wdata[7:0];
      wlane_d  = s_axi_wstrb[0];
    end
    // both halves present: perform the write and answer
    if (aw_held_q && w_held_q && !bvalid_q) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `TC_RESP_OKAY;
      if (waddr_q == `TC_CTRL_ADDR) begin
        ctrl_wr = wlane_q;
      end else if (waddr_q == `TC_CMP_ADDR) begin
        cmp_wr = wlane_q;
      end else begin
        bresp_d = `TC_RESP_SLVERR;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end
    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = `TC_RESP_OKAY;
      rdata_d   = 32'h0000_0000;
      if (s_axi_araddr == `TC_CTRL_ADDR) begin
        rdata_d[7:0] = ctrl_q & `TC_CTRL_MASK;
      end else if (s_axi_araddr == `TC_CMP_ADDR) begin
        rdata_d[7:0] = cmp_q;
      end else begin
        rresp_d = `TC_RESP_SLVERR;
      end
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      waddr_q   <= '0;
      wbyte_q   <= `TC_ZERO8;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `TC_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `TC_RESP_OKAY;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      waddr_q   <= waddr_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ---------------------------------------------------------------
  // source strobe selection
  // ---------------------------------------------------------------
  logic [2:0]              cksel;
  logic [1:0]              mode;
  logic                    run;
  logic [`TC_EXP_W-1:0]    fexp;
  logic [`TC_FAST_TAPS-1:0] tap_rise;
  src_e                    src;
  logic                    strobe;
  logic                    evt_rise, evt_fall;

  assign cksel    = ctrl_q[`TC_CKSEL_HI:`TC_CKSEL_LO];
  assign mode     = ctrl_q[`TC_MODE_HI:`TC_MODE_LO];
  assign run      = ctrl_q[`TC_RUN_BIT];
  assign tap_rise = fast_taps & ~taps_q;
  assign evt_rise = event_in & ~evt_q;
  assign evt_fall = ~event_in & evt_q;
  always_comb begin
    case (cksel)
      3'h0: fexp = `TC_EXP_C0;
      3'h1: fexp = `TC_EXP_C1;
      3'h2: fexp = `TC_EXP_C2;
      3'h3: fexp = `TC_EXP_C3;
      3'h4: fexp = `TC_EXP_C4;
      3'h5: fexp = `TC_EXP_C5;
      default: fexp = `TC_EXP_NONE;
    endcase
    fexp = fexp + {3'h0, prescaler_half_select};
  end
  always_comb begin
    if (cksel == `TC_CK_EVENT) begin
      src = src_event;
    end else if (slow_power_mode) begin
      src = (cksel == `TC_CK_SLOWCAP) ? src_slow : src_none;
    end else if (prescaler_slow_select && cksel == `TC_CK_SLOWCAP) begin
      src = src_slow;
    end else begin
      src = src_fast;
    end
  end
  always_comb begin
    case (src)
      src_fast: strobe = (fexp == `TC_EXP_NONE) ? 1'b1 : tap_rise[fexp - `TC_EXP_C5];
      src_slow: strobe = slow_tap & ~slow_q;
      default:  strobe = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // counter, outputs and control registers
  // ---------------------------------------------------------------
  byte_t cnt_inc;
  assign cnt_inc = cnt_q + `TC_CNT_ONE;

  always_comb begin
    ctrl_d   = ctrl_q;
    cmp_d    = cmp_q;
    shadow_d = shadow_q;
    cnt_d    = cnt_q;
    pdo_d    = pdo_q;
    pwm_n_d  = pwm_n_q;
    irq_d    = 1'b0;
    if (cmp_wr) begin
      cmp_d = wbyte_q;
    end
    if (ctrl_wr) begin
      ctrl_d = wbyte_q & `TC_CTRL_MASK;
    end
    if (stop_entry) begin
      ctrl_d[`TC_RUN_BIT] = 1'b0;
    end
    if (!run) begin
      cnt_d    = `TC_ZERO8;
      pdo_d    = 1'b1;
      pwm_n_d  = 1'b1;
      shadow_d = cmp_q;
    end else begin
      case (mode)
        `TC_MODE_TIMER: begin
          if (src == src_event) begin
            if (evt_rise) begin
              cnt_d = cnt_inc;
            end else if (evt_fall && cnt_q == cmp_q) begin
              cnt_d = `TC_ZERO8;
              irq_d = 1'b1;
            end
          end else if (strobe) begin
            if (cnt_inc == cmp_q) begin
              cnt_d = `TC_ZERO8;
              irq_d = 1'b1;
            end else begin
              cnt_d = cnt_inc;
            end
          end
        end
        `TC_MODE_PDO: begin
          if (strobe) begin
            if (cnt_inc == cmp_q) begin
              cnt_d = `TC_ZERO8;
              pdo_d = ~pdo_q;
              irq_d = 1'b1;
            end else begin
              cnt_d = cnt_inc;
            end
          end
        end
        `TC_MODE_PWM: begin
          if (strobe) begin
            cnt_d = cnt_inc;
            if (cnt_q == `TC_CNT_MAX) begin
              pwm_n_d  = 1'b1;
              irq_d    = 1'b1;
              shadow_d = cmp_q;
            end else if (cnt_inc == shadow_q) begin
              pwm_n_d = 1'b0;
            end
          end
        end
        default: cnt_d = `TC_ZERO8;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= `TC_CTRL_RESET;
      cmp_q    <= `TC_CMP_RESET;
      shadow_q <= `TC_CMP_RESET;
      cnt_q    <= `TC_ZERO8;
      pdo_q    <= 1'b1;
      pwm_n_q  <= 1'b1;
      irq_q    <= 1'b0;
      taps_q   <= '0;
      slow_q   <= 1'b0;
      evt_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      cmp_q    <= cmp_d;
      shadow_q <= shadow_d;
      cnt_q    <= cnt_d;
      pdo_q    <= pdo_d;
      pwm_n_q  <= pwm_n_d;
      irq_q    <= irq_d;
      taps_q   <= fast_taps;
      slow_q   <= slow_tap;
      evt_q    <= event_in;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign divider_out   = pdo_q;
  assign pwm_out_n     = pwm_n_q;
  assign match_irq     = irq_q;

endmodule : timer_counter

// ==== verilog/tc_defines.svh ====
// Purpose : constants for the 8-bit timer/counter block
// Assumes : included by bare name
// Notes   : offsets are register indexes; byte address is four times the index
`ifndef TC_DEFINES_SVH
`define TC_DEFINES_SVH

// register indexes and byte addresses
`define TC_CTRL_INDEX      8'h15
`define TC_CMP_INDEX       8'h19
`define TC_ADDR_W          8
`define TC_CTRL_ADDR       8'h54
`define TC_CMP_ADDR        8'h64

// control register fields
`define TC_RUN_BIT         5
`define TC_CKSEL_HI        4
`define TC_CKSEL_LO        2
`define TC_MODE_HI         1
`define TC_MODE_LO         0
`define TC_CTRL_MASK       8'h3F

// reset values
`define TC_CTRL_RESET      8'h00
`define TC_CMP_RESET       8'hFF

// operating mode codes
`define TC_MODE_TIMER      2'h0
`define TC_MODE_RSVD       2'h1
`define TC_MODE_PDO        2'h2
`define TC_MODE_PWM        2'h3

// source select codes and divisor exponents
`define TC_CK_SLOWCAP      3'h0
`define TC_CK_FAST         3'h6
`define TC_CK_EVENT        3'h7
`define TC_EXP_W           4
`define TC_FAST_TAPS       12
`define TC_EXP_C0          4'hB
`define TC_EXP_C1          4'h7
`define TC_EXP_C2          4'h5
`define TC_EXP_C3          4'h3
`define TC_EXP_C4          4'h2
`define TC_EXP_C5          4'h1
`define TC_EXP_NONE        4'h0

// bus answers and counter byte constants
`define TC_RESP_OKAY       2'h0
`define TC_RESP_SLVERR     2'h2
`define TC_CNT_MAX         8'hFF
`define TC_CNT_ONE         8'h01
`define TC_ZERO8           8'h00

`endif

// ==== verilog/tc_pkg.sv ====
// Purpose : shared types for the 8-bit timer/counter block
// Assumes : nothing
// Notes   : constants live in tc_defines.svh
package tc_pkg;

  typedef logic [7:0] byte_t;

  // where the counting strobe comes from
  typedef enum logic [1:0] {
    src_none,
    src_fast,
    src_slow,
    src_event
  } src_e;

endpackage : tc_pkg

// ==== verif/tc_monitor.sv ====
// Purpose: bus and pin checks on timer_counter
// Assumes: one clock, active-low reset
// Notes:   attached by bind below
`timescale 1ns/100ps
module tc_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        stop_entry,
  input wire logic        divider_out,
  input wire logic        pwm_out_n,
  input wire logic        match_irq
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  irq_pulse_a: assert property (match_irq |=> !match_irq)
    else $error("irq longer than one cycle");
  wr_answer_a: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  rd_answer_a: assert property (ar_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read data not held");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  pdo_fall_a: assert property ($fell(divider_out) |-> ##[0:1] match_irq)
    else $error("divider fell without irq");
  stop_idle_a: assert property (stop_entry ##1 stop_entry |=> divider_out && pwm_out_n)
    else $error("outputs not idle after stop");
  reset_out_a: assert property ($rose(rst_n) |-> divider_out && pwm_out_n && !match_irq)
    else $error("outputs wrong after reset");
endmodule : tc_monitor
bind timer_counter tc_monitor mon (.*);

// ==== verif/tc_far_end.sv ====
// Purpose: prescaler taps and event source for timer_counter
// Assumes: taps are levels of a free-running divider
// Notes:   event pin toggles every four cycles while enabled
`timescale 1ns/100ps
`include "tc_defines.svh"
module tc_far_end (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     ev_en,
  output logic [`TC_FAST_TAPS-1:0]      fast_taps,
  output logic                          slow_tap,
  output logic                          event_in
);
  // ----
  // divider and event pin
  // ----
  logic [11:0] cnt_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 12'h000;
      event_in <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 12'h001;
      if (cnt_q[1:0] == 2'h3) begin
        event_in <= ev_en & ~event_in;
      end
    end
  end
  assign fast_taps = cnt_q;
  assign slow_tap  = cnt_q[4];
endmodule : tc_far_end

// ==== verif/timer_counter_tb.sv ====
// Purpose: self-checking bench for timer_counter
// Assumes: far-end model drives taps and event pin
// Notes:   expectations in sys_clk cycles
`timescale 1ns/100ps
`include "tc_defines.svh"
module timer_counter_tb
  import tc_pkg::*;
;
  // ----
  // signals and models
  // ----
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        prescaler_slow_select = 1'b0;
  logic        prescaler_half_select = 1'b0;
  logic        slow_power_mode = 1'b0;
  logic        stop_entry = 1'b0;
  logic        ev_en = 1'b0;
  logic        ev_d = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [11:0] fast_taps;
  logic        slow_tap, event_in, divider_out, pwm_out_n, match_irq, v;
  int          failures = 0, compares = 0, cyc = 0, irqs = 0, rises = 0, n, lo, i0, r0;
  timer_counter uut (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'h1), .*);
  tc_far_end    far (.*);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    irqs <= irqs + int'(match_irq === 1'b1);
    ev_d <= event_in;
    rises <= rises + int'(event_in && !ev_d);
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  // ----
  // shared tasks
  // ----
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic done(input string s);
    $display("%s test done, failures %0d", s, failures);
  endtask : done
  task automatic wr(input logic [7:0] a, input byte_t d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input byte_t m, input byte_t e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata & {24'h000000, m}, {24'h000000, e});
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rdc
  task automatic run(input byte_t cfg);
    wr(`TC_CTRL_ADDR, cfg, `TC_RESP_OKAY);
    wr(`TC_CTRL_ADDR, cfg | 8'h20, `TC_RESP_OKAY);
  endtask : run
  task automatic wait_irq();
    do @(posedge sys_clk); while (match_irq !== 1'b1);
  endtask : wait_irq
  // cycles to the next irq, and cycles with the pwm pin low meanwhile
  task automatic gap(output int p, output int l);
    p = 0;
    l = 0;
    do begin
      @(posedge sys_clk);
      p++;
      l += int'(pwm_out_n === 1'b0);
    end while (match_irq !== 1'b1);
  endtask : gap
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rdc(`TC_CTRL_ADDR, 8'h3F, 8'h00, `TC_RESP_OKAY);
    rdc(`TC_CMP_ADDR, 8'hFF, 8'hFF, `TC_RESP_OKAY);
    wr(`TC_CMP_ADDR, 8'h5A, `TC_RESP_OKAY);
    rdc(`TC_CMP_ADDR, 8'hFF, 8'h5A, `TC_RESP_OKAY);
    wr(`TC_CTRL_ADDR, 8'hDF, `TC_RESP_OKAY);
    rdc(`TC_CTRL_ADDR, 8'h3F, 8'h1F, `TC_RESP_OKAY);
    wr(`TC_CTRL_ADDR, 8'h00, `TC_RESP_OKAY);
    wr(8'h00, 8'h12, `TC_RESP_SLVERR);
    rdc(8'h00, 8'h00, 8'h00, `TC_RESP_SLVERR);
    done("register");
  endtask : t_regs
  task automatic t_timer();
    wr(`TC_CMP_ADDR, 8'h03, `TC_RESP_OKAY);
    run(8'h0C);
    wait_irq();
    gap(n, lo);
    chk(n, 24);
    prescaler_half_select <= 1'b1;
    wait_irq();
    wait_irq();
    gap(n, lo);
    chk(n, 48);
    stop_entry <= 1'b1;
    repeat (2) @(posedge sys_clk);
    stop_entry <= 1'b0;
    rdc(`TC_CTRL_ADDR, 8'h3F, 8'h0C, `TC_RESP_OKAY);
    i0 = irqs;
    repeat (60) @(posedge sys_clk);
    chk(irqs - i0, 0);
    prescaler_half_select <= 1'b0;
    done("timer");
  endtask : t_timer
  task automatic t_pdo();
    wr(`TC_CMP_ADDR, 8'h02, `TC_RESP_OKAY);
    run(8'h0A);
    wait_irq();
    gap(n, lo);
    v = divider_out;
    chk(n, 64);
    gap(n, lo);
    chk(divider_out, !v);
    if (divider_out === 1'b1) wait_irq();
    wr(`TC_CTRL_ADDR, 8'h0A, `TC_RESP_OKAY);
    chk(divider_out, 1'b1);
    done("divider");
  endtask : t_pdo
  task automatic t_pwm();
    wr(`TC_CMP_ADDR, 8'h40, `TC_RESP_OKAY);
    run(8'h0F);
    wait_irq();
    wr(`TC_CMP_ADDR, 8'h80, `TC_RESP_OKAY);
    gap(n, lo);
    chk(lo, 1536);
    gap(n, lo);
    chk(n, 2048);
    chk(lo, 1024);
    repeat (1100) @(posedge sys_clk);
    chk(pwm_out_n, 1'b0);
    wr(`TC_CTRL_ADDR, 8'h0F, `TC_RESP_OKAY);
    chk(pwm_out_n, 1'b1);
    done("pwm");
  endtask : t_pwm
  task automatic t_event();
    wr(`TC_CMP_ADDR, 8'h03, `TC_RESP_OKAY);
    run(8'h1C);
    i0 = irqs;
    r0 = rises;
    ev_en <= 1'b1;
    repeat (60) @(posedge sys_clk);
    ev_en <= 1'b0;
    repeat (16) @(posedge sys_clk);
    chk(irqs - i0, (rises - r0) / 3);
    wr(`TC_CTRL_ADDR, 8'h1C, `TC_RESP_OKAY);
    done("event");
  endtask : t_event
  task automatic t_slow();
    prescaler_slow_select <= 1'b1;
    wr(`TC_CMP_ADDR, 8'h02, `TC_RESP_OKAY);
    run(8'h00);
    wait_irq();
    gap(n, lo);
    chk(n, 64);
    slow_power_mode <= 1'b1;
    wait_irq();
    gap(n, lo);
    chk(n, 64);
    wr(`TC_CTRL_ADDR, 8'h00, `TC_RESP_OKAY);
    slow_power_mode <= 1'b0;
    prescaler_slow_select <= 1'b0;
    run(8'h0D);
    i0 = irqs;
    repeat (100) @(posedge sys_clk);
    chk(irqs - i0, 0);
    wr(`TC_CTRL_ADDR, 8'h0D, `TC_RESP_OKAY);
    done("slow and reserved");
  endtask : t_slow
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_timer();
    t_pdo();
    t_pwm();
    t_event();
    t_slow();
    report_and_stop();
  end
endmodule : timer_counter_tb
